// ===== rtl/mwg_pkg.sv
package mwg_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_KHZ = 100_000;
	localparam int HOLD_MS_0 = 50;
	localparam int HOLD_MS_1 = 100;
	localparam int HOLD_MS_2 = 200;
	localparam int HOLD_MS_3 = 300;
	localparam int HOLD_CYC_0 = HOLD_MS_0 * CLK_KHZ;
	localparam int HOLD_CYC_1 = HOLD_MS_1 * CLK_KHZ;
	localparam int HOLD_CYC_2 = HOLD_MS_2 * CLK_KHZ;
	localparam int HOLD_CYC_3 = HOLD_MS_3 * CLK_KHZ;
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
	localparam int SCL_KHZ = 100;
	localparam int QUARTER_CYC = CLK_KHZ / (4 * SCL_KHZ);

	// ****************************************
	// Serial bus addresses and commands
	// ****************************************
	localparam logic [6:0] DEV_MEM = 7'h50;
	localparam logic [6:0] DEV_POT = 7'h51;
	localparam logic [6:0] DEV_CSR = 7'h52;
	localparam logic [7:0] CSR_ADDR = 8'hFF;
	localparam logic [7:0] WEL_CMD = 8'h02;
	localparam logic [7:0] RWEL_CMD = 8'h06;
	localparam logic [2:0][7:0] THR_RAISE_ADDR = {8'h0D, 8'h09, 8'h01};
	localparam logic [2:0][7:0] THR_RESET_ADDR = {8'h0F, 8'h0B, 8'h03};
	localparam int POT_NV_BIT = 7;

	// ****************************************
	// Control status register layout
	// ****************************************
	localparam int B_RESET_DELAY_SEL_LO = 0;
	localparam int B_WEL = 1;
	localparam int B_RWEL = 2;
	localparam int B_BL0 = 3;
	localparam int B_BL1 = 4;
	localparam int B_MONITOR3_STATUS = 5;
	localparam int B_MONITOR2_STATUS = 6;
	localparam int B_RESET_DELAY_SEL_HI = 7;
	localparam logic [7:0] CSR_RESET = 8'h01;

	// ****************************************
	// Thresholds in millivolts
	// ****************************************
	localparam logic [15:0] THR_NOMINAL_MV = 16'h06A4;
	localparam logic [15:0] THR_INIT_MV = 16'h0708;

	// ****************************************
	// Pin synchroniser bit order
	// ****************************************
	localparam int S_SCL = 0;
	localparam int S_SDA = 1;
	localparam int S_WP = 2;
	localparam int S_PROG = 3;
	localparam int S_MR = 4;
	localparam int S_SUP = 5;
	localparam int S_M2 = 6;
	localparam int S_M3 = 7;
	localparam logic [7:0] SYNC_IDLE = 8'h03;

	// ****************************************
	// Host register map and bit slots
	// ****************************************
	localparam logic [7:0] WB_CMD = 8'h00;
	localparam logic [7:0] WB_PINS = 8'h04;
	localparam logic [7:0] WB_STAT = 8'h08;
	localparam logic [4:0] LAST_SLOT = 5'h1A;
	localparam logic [4:0] ACK_SLOT0 = 5'h08;
	localparam logic [4:0] ACK_SLOT1 = 5'h11;

	typedef enum logic [1:0] {
		WK_POT_VOL = 2'b00,
		WK_POT_NV = 2'b01,
		WK_MEM = 2'b10,
		WK_CSR = 2'b11
	} mwg_kind_t;

	typedef enum logic [1:0] {
		SL_IDLE = 2'b00,
		SL_BITS = 2'b01,
		SL_ACK = 2'b10,
		SL_IGNORE = 2'b11
	} mwg_slave_t;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_START = 2'b01,
		HS_BITS = 2'b10,
		HS_STOP = 2'b11
	} mwg_host_t;

	// Lock codes guard the top quarter, top half or the whole array
	function automatic logic mem_locked(input logic [1:0] bl, input logic [7:0] a);
		case (bl)
			2'b01: mem_locked = a >= 8'hC0;
			2'b10: mem_locked = a >= 8'h80;
			2'b11: mem_locked = 1'b1;
			default: mem_locked = 1'b0;
		endcase
	endfunction

	function automatic logic write_ok(input mwg_kind_t k, input logic wp, input logic [1:0] bl,
			input logic locked);
		logic any_lock;
		any_lock = |bl;
		if (wp) begin
			write_ok = !any_lock && k == WK_POT_VOL;
		end else if (any_lock) begin
			write_ok = k == WK_CSR || (k == WK_MEM && !locked);
		end else begin
			write_ok = 1'b1;
		end
	endfunction

endpackage

// ===== rtl/mwg_link.sv
`timescale 1ns/1ns
interface mwg_link;
	// Open-drain lines: an enable pulls the wire low
	logic scl_o;
	logic scl_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;
	// Plain pins driven by the host
	logic wp_pin;
	logic prog_level;

	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

	modport host (
		output scl_o, scl_oe, sda_h_o, sda_h_oe, wp_pin, prog_level,
		input scl, sda
	);
	modport dev (
		output sda_d_o, sda_d_oe,
		input scl, sda, wp_pin, prog_level
	);
endinterface

// ===== rtl/mwg_device.sv
`timescale 1ns/1ns
module mwg_device #(
	parameter int HOLD0_CYC = mwg_pkg::HOLD_CYC_0,
	parameter int HOLD1_CYC = mwg_pkg::HOLD_CYC_1,
	parameter int HOLD2_CYC = mwg_pkg::HOLD_CYC_2,
	parameter int HOLD3_CYC = mwg_pkg::HOLD_CYC_3,
	parameter int DEB_CYC = mwg_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Serial link
	mwg_link.dev lk,
	// Supervisory pins
	input wire logic manual_reset_in,
	input wire logic supply_ok_in,
	input wire logic monitor2_trip,
	input wire logic monitor3_trip,
	input wire logic [2:0][15:0] applied_mv,
	output logic supply_reset_out,
	output logic monitor2_out,
	output logic monitor3_out,
	// State and threshold store
	output logic [7:0] control_status_reg,
	output logic [2:0][15:0] trip_threshold,
	output logic [2:0] thr_begin,
	output logic thr_busy,
	// Array and potentiometer write strobes
	output logic mem_wr_stb,
	output logic pot_wr_stb,
	output logic pot_wr_nv,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic write_rejected
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [7:0] s1_r, s2_r, s3_r, filt_r, prev_r;
	logic [7:0] agree;

	assign agree = ~(s2_r ^ s3_r);

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_r <= mwg_pkg::SYNC_IDLE;
			s2_r <= mwg_pkg::SYNC_IDLE;
			s3_r <= mwg_pkg::SYNC_IDLE;
			filt_r <= mwg_pkg::SYNC_IDLE;
			prev_r <= mwg_pkg::SYNC_IDLE;
		end else begin
			s1_r <= {monitor3_trip, monitor2_trip, supply_ok_in, manual_reset_in,
				lk.prog_level, lk.wp_pin, lk.sda, lk.scl};
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= (filt_r & ~agree) | (s3_r & agree);
			prev_r <= filt_r;
		end
	end

	logic scl_f, sda_f, wp_f, prog_f;
	assign scl_f = filt_r[mwg_pkg::S_SCL];
	assign sda_f = filt_r[mwg_pkg::S_SDA];
	assign wp_f = filt_r[mwg_pkg::S_WP];
	assign prog_f = filt_r[mwg_pkg::S_PROG];

	// ****************************************
	// Manual reset debounce and hold time
	// ****************************************
	logic mr_db_r;
	logic [31:0] deb_cnt_r, hold_cnt_r, hold_cyc;

	always_ff @(posedge mclk) begin
		if (rst) begin
			mr_db_r <= 1'b0;
			deb_cnt_r <= '0;
		end else if (filt_r[mwg_pkg::S_MR] == mr_db_r) begin
			deb_cnt_r <= '0;
		end else if (deb_cnt_r == 32'(DEB_CYC - 1)) begin
			mr_db_r <= filt_r[mwg_pkg::S_MR];
			deb_cnt_r <= '0;
		end else begin
			deb_cnt_r <= deb_cnt_r + 32'h1;
		end
	end

	always_comb begin
		case ({control_status_reg[mwg_pkg::B_RESET_DELAY_SEL_HI], control_status_reg[mwg_pkg::B_RESET_DELAY_SEL_LO]})
			2'b00: hold_cyc = 32'(HOLD0_CYC);
			2'b01: hold_cyc = 32'(HOLD1_CYC);
			2'b10: hold_cyc = 32'(HOLD2_CYC);
			default: hold_cyc = 32'(HOLD3_CYC);
		endcase
	end

	// Reset starts asserted so the hold time also covers power-up
	always_ff @(posedge mclk) begin
		if (rst) begin
			supply_reset_out <= 1'b1;
			hold_cnt_r <= '0;
		end else if (mr_db_r || !filt_r[mwg_pkg::S_SUP]) begin
			supply_reset_out <= 1'b1;
			hold_cnt_r <= '0;
		end else if (supply_reset_out) begin
			if (hold_cnt_r >= hold_cyc - 32'h1) begin
				supply_reset_out <= 1'b0;
				hold_cnt_r <= '0;
			end else begin
				hold_cnt_r <= hold_cnt_r + 32'h1;
			end
		end
	end

	// ****************************************
	// Voltage monitor outputs
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			monitor2_out <= 1'b0;
			monitor3_out <= 1'b0;
		end else begin
			monitor2_out <= filt_r[mwg_pkg::S_M2];
			monitor3_out <= filt_r[mwg_pkg::S_M3];
		end
	end

	// ****************************************
	// Serial slave
	// ****************************************
	mwg_pkg::mwg_slave_t st_r;
	logic [3:0] bitc_r;
	logic [1:0] bytec_r;
	logic [7:0] sh_r, addr_r, data_r;
	logic [6:0] dev_r;
	logic prog_at_start_r, sda_oe_r;
	logic scl_rise, scl_fall, start_c, stop_c, commit;

	assign scl_rise = scl_f && !prev_r[mwg_pkg::S_SCL];
	assign scl_fall = !scl_f && prev_r[mwg_pkg::S_SCL];
	assign start_c = scl_f && prev_r[mwg_pkg::S_SCL] && !sda_f && prev_r[mwg_pkg::S_SDA];
	assign stop_c = scl_f && prev_r[mwg_pkg::S_SCL] && sda_f && !prev_r[mwg_pkg::S_SDA];
	// Three acknowledged bytes; the clock pulse that carries STOP counts one bit
	assign commit = stop_c && st_r == mwg_pkg::SL_BITS && bytec_r == 2'h3 && bitc_r == 4'h1;
	assign lk.sda_d_o = 1'b0;
	assign lk.sda_d_oe = sda_oe_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= mwg_pkg::SL_IDLE;
			bitc_r <= '0;
			bytec_r <= '0;
			sh_r <= '0;
			dev_r <= '0;
			addr_r <= '0;
			data_r <= '0;
			prog_at_start_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (start_c) begin
			st_r <= mwg_pkg::SL_BITS;
			bitc_r <= '0;
			bytec_r <= '0;
			prog_at_start_r <= prog_f;
			sda_oe_r <= 1'b0;
		end else if (stop_c) begin
			st_r <= mwg_pkg::SL_IDLE;
			sda_oe_r <= 1'b0;
		end else begin
			case (st_r)
				mwg_pkg::SL_BITS: begin
					if (scl_rise && bitc_r != 4'h8) begin
						sh_r <= {sh_r[6:0], sda_f};
						bitc_r <= bitc_r + 4'h1;
					end else if (scl_fall && bitc_r == 4'h8) begin
						bitc_r <= '0;
						if (bytec_r == 2'h0 && !sh_r[0] && (sh_r[7:1] == mwg_pkg::DEV_MEM
								|| sh_r[7:1] == mwg_pkg::DEV_POT
								|| sh_r[7:1] == mwg_pkg::DEV_CSR)) begin
							dev_r <= sh_r[7:1];
							sda_oe_r <= 1'b1;
							st_r <= mwg_pkg::SL_ACK;
						end else if (bytec_r == 2'h1 || bytec_r == 2'h2) begin
							if (bytec_r == 2'h1) begin
								addr_r <= sh_r;
							end else begin
								data_r <= sh_r;
							end
							sda_oe_r <= 1'b1;
							st_r <= mwg_pkg::SL_ACK;
						end else begin
							st_r <= mwg_pkg::SL_IGNORE;
						end
					end
				end
				mwg_pkg::SL_ACK: begin
					if (scl_fall) begin
						sda_oe_r <= 1'b0;
						bytec_r <= bytec_r + 2'h1;
						st_r <= mwg_pkg::SL_BITS;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Command decode at STOP
	// ****************************************
	logic [2:0] hit_raise, hit_reset;
	logic thr_cmd, is_mem, is_pot, is_csr, ok;
	logic [1:0] bl;
	mwg_pkg::mwg_kind_t kind;

	assign bl = {control_status_reg[mwg_pkg::B_BL1], control_status_reg[mwg_pkg::B_BL0]};

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			hit_raise[i] = addr_r == mwg_pkg::THR_RAISE_ADDR[i];
			hit_reset[i] = addr_r == mwg_pkg::THR_RESET_ADDR[i];
		end
	end

	assign thr_cmd = dev_r == mwg_pkg::DEV_MEM && prog_at_start_r && data_r == 8'h00
		&& |(hit_raise | hit_reset);
	assign is_mem = dev_r == mwg_pkg::DEV_MEM && !prog_at_start_r;
	assign is_pot = dev_r == mwg_pkg::DEV_POT;
	assign is_csr = dev_r == mwg_pkg::DEV_CSR && addr_r == mwg_pkg::CSR_ADDR;
	assign kind = is_csr ? mwg_pkg::WK_CSR : is_mem ? mwg_pkg::WK_MEM
		: addr_r[mwg_pkg::POT_NV_BIT] ? mwg_pkg::WK_POT_NV : mwg_pkg::WK_POT_VOL;
	// Array and potentiometer writes also need the write enable latch
	assign ok = mwg_pkg::write_ok(kind, wp_f, bl, mwg_pkg::mem_locked(bl, addr_r))
		&& (is_csr || control_status_reg[mwg_pkg::B_WEL]);

	always_ff @(posedge mclk) begin
		if (rst) begin
			mem_wr_stb <= 1'b0;
			pot_wr_stb <= 1'b0;
			pot_wr_nv <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			write_rejected <= 1'b0;
		end else begin
			mem_wr_stb <= commit && is_mem && ok;
			pot_wr_stb <= commit && is_pot && ok;
			write_rejected <= commit && (is_mem || is_pot || is_csr) && !ok;
			if (commit) begin
				pot_wr_nv <= addr_r[mwg_pkg::POT_NV_BIT];
				wr_addr <= addr_r;
				wr_data <= data_r;
			end
		end
	end

	// ****************************************
	// Trip thresholds
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			trip_threshold <= {3{mwg_pkg::THR_INIT_MV}};
			thr_begin <= '0;
			thr_busy <= 1'b0;
		end else begin
			thr_begin <= (commit && thr_cmd) ? (hit_raise | hit_reset) : 3'h0;
			if (commit && thr_cmd) begin
				thr_busy <= 1'b1;
			end else if (!prog_f) begin
				thr_busy <= 1'b0;
			end
			for (int i = 0; i < 3; i++) begin
				if (commit && thr_cmd && hit_reset[i]) begin
					trip_threshold[i] <= mwg_pkg::THR_NOMINAL_MV;
				end else if (commit && thr_cmd && hit_raise[i]
						&& applied_mv[i] > trip_threshold[i]) begin
					trip_threshold[i] <= applied_mv[i];
				end
			end
		end
	end

	// ****************************************
	// Control status register
	// ****************************************
	logic csr_wr, m2_rise, m3_rise;
	assign csr_wr = commit && is_csr && ok;
	assign m2_rise = filt_r[mwg_pkg::S_M2] && !monitor2_out;
	assign m3_rise = filt_r[mwg_pkg::S_M3] && !monitor3_out;

	always_ff @(posedge mclk) begin
		if (rst) begin
			control_status_reg <= mwg_pkg::CSR_RESET;
		end else begin
			if (m2_rise || !monitor2_out) begin
				control_status_reg[mwg_pkg::B_MONITOR2_STATUS] <= 1'b0;
			end
			if (m3_rise || !monitor3_out) begin
				control_status_reg[mwg_pkg::B_MONITOR3_STATUS] <= 1'b0;
			end
			if (csr_wr) begin
				if (data_r == mwg_pkg::WEL_CMD) begin
					control_status_reg[mwg_pkg::B_WEL] <= 1'b1;
				end else if (data_r == mwg_pkg::RWEL_CMD) begin
					control_status_reg[mwg_pkg::B_WEL] <= 1'b1;
					control_status_reg[mwg_pkg::B_RWEL] <= control_status_reg[mwg_pkg::B_WEL];
				end else if (control_status_reg[mwg_pkg::B_RWEL]
						&& !data_r[mwg_pkg::B_RWEL]) begin
					control_status_reg[mwg_pkg::B_RESET_DELAY_SEL_HI] <= data_r[mwg_pkg::B_RESET_DELAY_SEL_HI];
					control_status_reg[mwg_pkg::B_RESET_DELAY_SEL_LO] <= data_r[mwg_pkg::B_RESET_DELAY_SEL_LO];
					control_status_reg[mwg_pkg::B_BL1] <= data_r[mwg_pkg::B_BL1];
					control_status_reg[mwg_pkg::B_BL0] <= data_r[mwg_pkg::B_BL0];
					control_status_reg[mwg_pkg::B_RWEL] <= 1'b0;
					control_status_reg[mwg_pkg::B_WEL] <= 1'b0;
					// Set wins over the clear; only possible while the output is high
					if (data_r[mwg_pkg::B_MONITOR2_STATUS] && filt_r[mwg_pkg::S_M2] && monitor2_out) begin
						control_status_reg[mwg_pkg::B_MONITOR2_STATUS] <= 1'b1;
					end
					if (data_r[mwg_pkg::B_MONITOR3_STATUS] && filt_r[mwg_pkg::S_M3] && monitor3_out) begin
						control_status_reg[mwg_pkg::B_MONITOR3_STATUS] <= 1'b1;
					end
				end
			end
		end
	end

endmodule // mwg_device

// ===== rtl/mwg_host.sv
`timescale 1ns/1ns
module mwg_host #(
	parameter int QCYC = mwg_pkg::QUARTER_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial link
	mwg_link.host lk
);

	// ****************************************
	// Register access
	// ****************************************
	logic [23:0] cmd_r;
	logic [1:0] pins_r;
	logic busy_r, nack_r, go;
	logic req;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// A command written while busy is acknowledged but dropped
	assign go = req && wb_we_i && wb_adr_i == mwg_pkg::WB_CMD && !busy_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			cmd_r <= '0;
			pins_r <= '0;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				case (wb_adr_i)
					mwg_pkg::WB_CMD: wb_dat_o <= {8'h00, cmd_r};
					mwg_pkg::WB_PINS: wb_dat_o <= {30'h0, pins_r};
					mwg_pkg::WB_STAT: wb_dat_o <= {30'h0, nack_r, busy_r};
					default: wb_dat_o <= '0;
				endcase
			end
			if (go) begin
				for (int i = 0; i < 3; i++) begin
					if (wb_sel_i[i]) begin
						cmd_r[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
					end
				end
			end
			if (req && wb_we_i && wb_adr_i == mwg_pkg::WB_PINS && wb_sel_i[0]) begin
				pins_r <= wb_dat_i[1:0];
			end
		end
	end

	assign lk.wp_pin = pins_r[0];
	assign lk.prog_level = pins_r[1];

	// ****************************************
	// Data line synchroniser
	// ****************************************
	logic sd1_r, sd2_r, sd3_r, sda_f_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sd1_r <= 1'b1;
			sd2_r <= 1'b1;
			sd3_r <= 1'b1;
			sda_f_r <= 1'b1;
		end else begin
			sd1_r <= lk.sda;
			sd2_r <= sd1_r;
			sd3_r <= sd2_r;
			if (sd2_r == sd3_r) begin
				sda_f_r <= sd3_r;
			end
		end
	end

	// ****************************************
	// Bit engine, four ticks per bit
	// ****************************************
	mwg_pkg::mwg_host_t st_r;
	logic [31:0] div_r;
	logic tick;
	logic [1:0] ph_r;
	logic [4:0] slot_r;
	logic [26:0] sh_r;
	logic scl_oe_r, sda_oe_r;

	assign tick = div_r == 32'(QCYC - 1);
	assign lk.scl_o = 1'b0;
	assign lk.sda_h_o = 1'b0;
	assign lk.scl_oe = scl_oe_r;
	assign lk.sda_h_oe = sda_oe_r;

	always_ff @(posedge mclk) begin
		if (rst || go || tick) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 32'h1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= mwg_pkg::HS_IDLE;
			busy_r <= 1'b0;
			nack_r <= 1'b0;
			ph_r <= '0;
			slot_r <= '0;
			sh_r <= '0;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else if (go) begin
			st_r <= mwg_pkg::HS_START;
			busy_r <= 1'b1;
			nack_r <= 1'b0;
			ph_r <= '0;
			slot_r <= '0;
			// Ninth bit of each byte is released for the acknowledge
			sh_r <= {wb_dat_i[7:0], 1'b1, wb_dat_i[15:8], 1'b1, wb_dat_i[23:16], 1'b1};
		end else if (tick) begin
			ph_r <= ph_r + 2'h1;
			case (st_r)
				mwg_pkg::HS_START: begin
					if (ph_r == 2'h2) begin
						sda_oe_r <= 1'b1;
					end else if (ph_r == 2'h3) begin
						scl_oe_r <= 1'b1;
						st_r <= mwg_pkg::HS_BITS;
					end
				end
				mwg_pkg::HS_BITS: begin
					case (ph_r)
						2'h0: sda_oe_r <= !sh_r[26];
						2'h1: scl_oe_r <= 1'b0;
						2'h2: begin
							if ((slot_r == mwg_pkg::ACK_SLOT0 || slot_r == mwg_pkg::ACK_SLOT1
									|| slot_r == mwg_pkg::LAST_SLOT) && sda_f_r) begin
								nack_r <= 1'b1;
							end
						end
						default: begin
							scl_oe_r <= 1'b1;
							sh_r <= {sh_r[25:0], 1'b1};
							slot_r <= slot_r + 5'h1;
							if (slot_r == mwg_pkg::LAST_SLOT) begin
								st_r <= mwg_pkg::HS_STOP;
							end
						end
					endcase
				end
				mwg_pkg::HS_STOP: begin
					case (ph_r)
						2'h0: sda_oe_r <= 1'b1;
						2'h1: scl_oe_r <= 1'b0;
						2'h2: sda_oe_r <= 1'b0;
						default: begin
							st_r <= mwg_pkg::HS_IDLE;
							busy_r <= 1'b0;
						end
					endcase
				end
				default: begin
				end
			endcase
		end
	end

endmodule // mwg_host

// ===== verif/mwg_sva.sv
`timescale 1ns/1ns
module mwg_sva #(
	parameter int DEB_CYC = mwg_pkg::DEBOUNCE_CYC,
	parameter int HOLD1_CYC = mwg_pkg::HOLD_CYC_1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Link wires
	input wire logic scl,
	input wire logic sda,
	input wire logic prog_level,
	// Supervisory pins
	input wire logic manual_reset_in,
	input wire logic monitor2_trip,
	input wire logic monitor3_trip,
	input wire logic supply_reset_out,
	input wire logic monitor2_out,
	input wire logic monitor3_out,
	input wire logic [7:0] control_status_reg,
	input wire logic [2:0] thr_begin,
	input wire logic thr_busy
);
	logic sda_r;
	logic [7:0] stop_age_r;
	int mr_hi_r;
	int mr_lo_r;

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// ****************************************
	// Helper counters
	// ****************************************
	// Age saturates so a stale STOP never excuses a late threshold cycle
	always_ff @(posedge mclk) begin
		sda_r <= sda;
		if (rst) begin
			stop_age_r <= 8'hFF;
		end else if (scl && sda && !sda_r) begin
			stop_age_r <= 8'h00;
		end else if (stop_age_r != 8'hFF) begin
			stop_age_r <= stop_age_r + 8'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mr_hi_r <= 0;
			mr_lo_r <= 0;
		end else begin
			mr_hi_r <= manual_reset_in ? mr_hi_r + 1 : 0;
			mr_lo_r <= manual_reset_in ? 0 : mr_lo_r + 1;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	mon2_follow_a: assert property (monitor2_trip [*6] |-> monitor2_out)
		else $error("monitor2 output missed its trip");
	mon3_follow_a: assert property (monitor3_trip [*6] |-> monitor3_out)
		else $error("monitor3 output missed its trip");
	stat2_clear_a: assert property ($rose(monitor2_out) |=> !control_status_reg[6])
		else $error("monitor2 status not cleared");
	stat3_clear_a: assert property ($rose(monitor3_out) |=> !control_status_reg[5])
		else $error("monitor3 status not cleared");
	mr_force_a: assert property (mr_hi_r > DEB_CYC + 8 |-> supply_reset_out)
		else $error("manual reset did not force reset out");
	hold_time_a: assert property ($fell(supply_reset_out) |-> mr_lo_r >= HOLD1_CYC)
		else $error("reset out released before hold time");
	thr_stop_a: assert property (|thr_begin |-> stop_age_r < 8'h10)
		else $error("threshold cycle began without STOP");
	busy_hold_a: assert property (thr_busy && prog_level |=> thr_busy)
		else $error("threshold busy dropped with level high");
endmodule // mwg_sva

// ===== verif/tb_monitor_write_guard.sv
`timescale 1ns/1ns
module tb_monitor_write_guard;
	logic mclk, rst, cyc, stb, we, ack, mr, m2, m3, srst, mo2, mo3, busy, mstb, pstb;
	logic sok, wnv, rej;
	logic [3:0] sel;
	logic [7:0] adr, csr, wa, wd;
	logic [31:0] dat, rdo, rd;
	logic [2:0][15:0] amv, thr;
	logic [2:0] tbeg;
	int error_cnt, tests_run, okc, cyc_cnt, rjc;

	mwg_link lk ();
	mwg_host #(.QCYC(8)) mwg_host_inst (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo),
		.wb_ack_o(ack), .lk(lk.host));
	mwg_device #(.HOLD0_CYC(50), .HOLD1_CYC(100), .HOLD2_CYC(200), .HOLD3_CYC(300),
		.DEB_CYC(20)) mwg_device_inst (.mclk(mclk), .rst(rst), .lk(lk.dev),
		.manual_reset_in(mr), .supply_ok_in(sok), .monitor2_trip(m2), .monitor3_trip(m3),
		.applied_mv(amv), .supply_reset_out(srst), .monitor2_out(mo2), .monitor3_out(mo3),
		.control_status_reg(csr), .trip_threshold(thr), .thr_begin(tbeg), .thr_busy(busy),
		.mem_wr_stb(mstb), .pot_wr_stb(pstb), .pot_wr_nv(wnv), .wr_addr(wa), .wr_data(wd),
		.write_rejected(rej));
	mwg_sva #(.DEB_CYC(20), .HOLD1_CYC(100)) mwg_sva_inst (.mclk(mclk), .rst(rst),
		.scl(lk.scl), .sda(lk.sda), .prog_level(lk.prog_level), .manual_reset_in(mr),
		.monitor2_trip(m2), .monitor3_trip(m3), .supply_reset_out(srst), .monitor2_out(mo2),
		.monitor3_out(mo3), .control_status_reg(csr), .thr_begin(tbeg), .thr_busy(busy));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Accepted write strobes and the hang limit
	always @(posedge mclk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (mstb === 1'b1 || pstb === 1'b1) begin
			okc <= okc + 1;
		end
		if (rej === 1'b1) begin
			rjc <= rjc + 1;
		end
		if (cyc_cnt == 90000) begin
			error_cnt++;
			final_report();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		rd = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] d);
		wb(1'b1, mwg_pkg::WB_CMD, {8'h00, d, b, a});
		do wb(1'b0, mwg_pkg::WB_STAT, 32'h0); while (rd[0] === 1'b1);
		repeat (20) @(posedge mclk);
	endtask

	task automatic pins(input logic w, input logic p);
		wb(1'b1, mwg_pkg::WB_PINS, {30'h0, p, w});
	endtask

	task automatic csr_seq(input logic [7:0] d);
		frame(8'hA4, 8'hFF, 8'h02);
		frame(8'hA4, 8'hFF, 8'h06);
		frame(8'hA4, 8'hFF, d);
	endtask

	// Every write gets the enable latch first so only permission decides
	task automatic wr(input logic [7:0] a, input logic [7:0] b, input int e);
		int n;
		int r;
		frame(8'hA4, 8'hFF, 8'h02);
		n = okc;
		r = rjc;
		frame(a, b, 8'h5A);
		check(okc - n, e);
		check(rjc - r, 1 - e);
		check({wnv, wa, wd}, {b[7], b, 8'h5A});
	endtask

	task automatic thr_cmd(input int i, input logic up, input logic [15:0] mv,
			input logic [15:0] e);
		logic [2:0][15:0] v;
		v = amv;
		v[i] = mv;
		amv <= v;
		pins(1'b0, 1'b1);
		frame(8'hA0, up ? mwg_pkg::THR_RAISE_ADDR[i] : mwg_pkg::THR_RESET_ADDR[i], 8'h00);
		pins(1'b0, 1'b0);
		repeat (10) @(posedge mclk);
		check(thr[i], e);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		{cyc, stb, we, mr, m2, m3} = 6'h00;
		adr = 8'h00;
		dat = 32'h0;
		amv = '0;
		{okc, cyc_cnt, error_cnt, tests_run, rjc} = '0;
		sok = 1'b1;
		sel = 4'hF;
		rst = 1'b1;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (50) @(posedge mclk);
		check(srst, 1'b1);
		repeat (100) @(posedge mclk);
		check(srst, 1'b0);
		mr <= 1'b1;
		repeat (10) @(posedge mclk);
		mr <= 1'b0;
		repeat (30) @(posedge mclk);
		check(srst, 1'b0);
		mr <= 1'b1;
		repeat (40) @(posedge mclk);
		check(srst, 1'b1);
		mr <= 1'b0;
		repeat (60) @(posedge mclk);
		check(srst, 1'b1);
		repeat (100) @(posedge mclk);
		check(srst, 1'b0);
		$display("manual reset test done");
		csr_seq(8'h61);
		check(csr[6:5], 2'b00);
		{m2, m3} <= 2'b11;
		repeat (8) @(posedge mclk);
		check({mo3, mo2}, 2'b11);
		csr_seq(8'h61);
		check(csr[6:5], 2'b11);
		{m2, m3} <= 2'b00;
		repeat (8) @(posedge mclk);
		check(csr[6:5], 2'b00);
		$display("monitor test done");
		csr_seq(8'h81);
		check({csr[7], csr[0]}, 2'b11);
		sok <= 1'b0;
		repeat (10) @(posedge mclk);
		check(srst, 1'b1);
		sok <= 1'b1;
		repeat (250) @(posedge mclk);
		check(srst, 1'b1);
		repeat (100) @(posedge mclk);
		check(srst, 1'b0);
		$display("delay select test done");
		for (int i = 0; i < 3; i++) begin
			thr_cmd(i, 1'b1, 16'h0800, 16'h0800);
			thr_cmd(i, 1'b1, 16'h0780, 16'h0800);
			thr_cmd(i, 1'b0, 16'h0000, mwg_pkg::THR_NOMINAL_MV);
			thr_cmd(i, 1'b1, 16'h07F0, 16'h07F0);
		end
		$display("threshold test done");
		wr(8'hA2, 8'h00, 1);
		wr(8'hA2, 8'h80, 1);
		wr(8'hA0, 8'h10, 1);
		pins(1'b1, 1'b0);
		wr(8'hA2, 8'h00, 1);
		wr(8'hA2, 8'h80, 0);
		wr(8'hA0, 8'h10, 0);
		csr_seq(8'h09);
		check(csr[4:3], 2'b00);
		pins(1'b0, 1'b0);
		csr_seq(8'h09);
		check(csr[4:3], 2'b01);
		wr(8'hA2, 8'h00, 0);
		wr(8'hA0, 8'hC0, 0);
		wr(8'hA0, 8'h10, 1);
		pins(1'b1, 1'b0);
		wr(8'hA2, 8'h00, 0);
		wr(8'hA0, 8'h10, 0);
		csr_seq(8'h01);
		check(csr[4:3], 2'b01);
		$display("permission test done");
		sel <= 4'hE;
		pins(1'b0, 1'b1);
		sel <= 4'hF;
		wb(1'b0, mwg_pkg::WB_PINS, 32'h0);
		check(rd, 32'h1);
		frame(8'hB0, 8'h00, 8'h00);
		check(rd[1:0], 2'b10);
		wb(1'b0, 8'h0C, 32'h0);
		check(rd, 32'h0);
		$display("host register test done");
		final_report();
	end
endmodule // tb_monitor_write_guard
